// File: design/sercol_collector.sv
/*
  event request collector: network side 16-bit and host side 32-bit event
  request words, their masks, the host interrupt and the frame event field.
  assumes source blocks deliver status levels and one-cycle change, read
  and acknowledge pulses synchronous to i_sys_clk.
*/
// Contract
// - net bits 11:4 mirror channel 7..0 status
// - net bit 3: set on status change, read clears
// - net bit 2: data link change, read clears
// - net bit 0: latch change, master read clears
// - net word read-only at 0210h, reserved bits
// - host word read-only at 0220h, reserved bits
// - host bits 15:8 show channel interrupts
// - host bit 6: watchdog expired, read clears
// - host bit 5: eeprom command until acknowledged
// - host bit 4: activate change, read clears
// - host bit 3: second sync, cfg bit 7
// - host bit 2: first sync, cfg bit 3
// - host bit 1: latch change, host read clears
// - host bit 0: control write, emulation off only
// - control event cleared by host control read
// - low byte at lowest byte address
// - host mask at 0204h, reset 00ffff0fh
// - network mask at 0200h, reset zero
`timescale 1ns/1ns
module sercol_collector
  import sercol_pkg::*;
#(
  parameter int NUM_SM = 8
)
(
  input wire logic i_sys_clk, // core clock, 250 MHz
  input wire logic i_rst, // async reset, active high
  // network master register port
  input wire logic [11:0] i_net_addr, // byte address
  input wire logic i_net_rd, // read strobe
  input wire logic i_net_wr, // write strobe
  input wire logic [3:0] i_net_be, // byte enables
  input wire logic [31:0] i_net_wdata, // write data
  output logic [31:0] o_net_rdata, // read data, next cycle
  // host register port
  input wire logic [11:0] i_host_addr, // byte address
  input wire logic i_host_rd, // read strobe
  input wire logic i_host_wr, // write strobe
  input wire logic [3:0] i_host_be, // byte enables
  input wire logic [31:0] i_host_wdata, // write data
  output logic [31:0] o_host_rdata, // read data, next cycle
  // event sources
  input wire logic [NUM_SM-1:0] i_sm_status, // channel event pending
  input wire logic [2*NUM_SM-1:0] i_sm_irq_bits, // bits 1:0 per channel
  input wire logic i_al_status_change, // status changed pulse
  input wire logic i_al_status_net_read, // master read status
  input wire logic i_dl_status_change, // link status changed
  input wire logic i_dl_status_net_read, // master read link status
  input wire logic i_latch_change, // latch input changed
  input wire logic i_latch_net_read, // master read its latch times
  input wire logic i_latch_host_read, // host read its latch times
  input wire logic i_wdog_expired, // watchdog expiry pulse
  input wire logic i_wdog_status_read, // watchdog status read
  input wire logic i_eeprom_cmd, // eeprom command issued
  input wire logic i_eeprom_ack, // host acknowledged command
  input wire logic i_sm_act_change, // any activate reg changed
  input wire logic i_sm_act_host_read, // host read activate reg
  input wire logic i_first_sync_output, // first sync output pulse
  input wire logic i_second_sync_output, // second sync output pulse
  input wire logic [7:0] i_sync_latch_cfg, // sync/latch host cfg
  input wire logic i_first_sync_output_status_read, // 0x098e read
  input wire logic i_second_sync_output_status_read, // 0x098f read
  input wire logic i_al_control_write, // control register written
  input wire logic i_al_control_host_read, // host read control reg
  input wire logic i_host_emulation, // controller cfg bit 8
  // event outputs
  output logic o_host_interrupt_request, // level, active high
  output logic [15:0] o_net_event_field // masked net events
);
  localparam int NF = SERCOL_NUM_FLAGS;

  typedef struct packed {
    logic [15:0] net_mask;
    logic [31:0] host_mask;
    logic [NUM_SM-1:0] sm_mirror;
    logic [NUM_SM-1:0] sm_irq;
    logic [31:0] net_rdata;
    logic [31:0] host_rdata;
    logic host_irq;
    logic [15:0] net_field;
  } sercol_state_type;

  sercol_state_type r;
  sercol_state_type next_r;
  logic [NF-1:0] flag_set;
  logic [NF-1:0] flag_clr;
  logic [NF-1:0] flags;
  logic [15:0] net_req;
  logic [31:0] host_req;

  // word hit on a byte address, low two bits ignored
  function automatic logic word_hit(input logic [11:0] a, input logic [11:0] off);
    return a[11:2] == off[11:2];
  endfunction : word_hit

  // merge write data into a word under byte enables
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        res[8*i +: 8] = wd[8*i +: 8];
    end
    return res;
  endfunction : lane_merge

  // fold two interrupt bits per channel into one
  function automatic logic [NUM_SM-1:0] fold_irq(input logic [2*NUM_SM-1:0] b);
    logic [NUM_SM-1:0] res;
    res = '0;
    for (int i = 0; i < NUM_SM; i++)
      res[i] = b[2*i] | b[2*i+1];
    return res;
  endfunction : fold_irq

  // set conditions for the sticky flags
  always_comb
  begin
    flag_set = '0;
    flag_set[SERCOL_F_NET_AL] = i_al_status_change;
    flag_set[SERCOL_F_NET_DL] = i_dl_status_change;
    flag_set[SERCOL_F_NET_LATCH] = i_latch_change;
    flag_set[SERCOL_F_AL_CTL] = i_al_control_write & ~i_host_emulation;
    flag_set[SERCOL_F_H_LATCH] = i_latch_change;
    // first sync gated by cfg bit 3
    flag_set[SERCOL_F_FIRST_SYNC_OUTPUT] = i_first_sync_output & i_sync_latch_cfg[SERCOL_CFG_FIRST_SYNC_OUTPUT_EN];
    // second sync gated by cfg bit 7
    flag_set[SERCOL_F_SECOND_SYNC_OUTPUT] = i_second_sync_output & i_sync_latch_cfg[SERCOL_CFG_SECOND_SYNC_OUTPUT_EN];
    flag_set[SERCOL_F_SM_ACT] = i_sm_act_change;
    flag_set[SERCOL_F_EEPROM] = i_eeprom_cmd;
    flag_set[SERCOL_F_WDOG] = i_wdog_expired;
  end

  // clear conditions, all from source reads or acknowledges
  always_comb
  begin
    flag_clr = '0;
    flag_clr[SERCOL_F_NET_AL] = i_al_status_net_read;
    flag_clr[SERCOL_F_NET_DL] = i_dl_status_net_read;
    flag_clr[SERCOL_F_NET_LATCH] = i_latch_net_read;
    flag_clr[SERCOL_F_AL_CTL] = i_al_control_host_read;
    flag_clr[SERCOL_F_H_LATCH] = i_latch_host_read;
    flag_clr[SERCOL_F_FIRST_SYNC_OUTPUT] = i_first_sync_output_status_read;
    flag_clr[SERCOL_F_SECOND_SYNC_OUTPUT] = i_second_sync_output_status_read;
    flag_clr[SERCOL_F_SM_ACT] = i_sm_act_host_read;
    flag_clr[SERCOL_F_EEPROM] = i_eeprom_ack;
    flag_clr[SERCOL_F_WDOG] = i_wdog_status_read;
  end

  // sticky flags; a set in the clear cycle survives
  sercol_flag_bank #(
    .W(NF)
  ) u_flags (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_set(flag_set),
    .i_clr(flag_clr),
    .o_flags(flags)
  );

  // assemble request words; reserved bits tied low
  always_comb
  begin
    net_req = '0;
    host_req = '0;
    net_req[SERCOL_NET_SM_LO +: NUM_SM] = r.sm_mirror;
    net_req[SERCOL_NET_AL_STAT] = flags[SERCOL_F_NET_AL];
    net_req[SERCOL_NET_DL_STAT] = flags[SERCOL_F_NET_DL];
    net_req[SERCOL_NET_LATCH] = flags[SERCOL_F_NET_LATCH];
    host_req[SERCOL_HOST_SM_LO +: NUM_SM] = r.sm_irq;
    host_req[SERCOL_HOST_WDOG] = flags[SERCOL_F_WDOG];
    host_req[SERCOL_HOST_EEPROM] = flags[SERCOL_F_EEPROM];
    host_req[SERCOL_HOST_SM_ACT] = flags[SERCOL_F_SM_ACT];
    host_req[SERCOL_HOST_SECOND_SYNC_OUTPUT] = flags[SERCOL_F_SECOND_SYNC_OUTPUT];
    host_req[SERCOL_HOST_FIRST_SYNC_OUTPUT] = flags[SERCOL_F_FIRST_SYNC_OUTPUT];
    host_req[SERCOL_HOST_LATCH] = flags[SERCOL_F_H_LATCH];
    host_req[SERCOL_HOST_AL_CTL] = flags[SERCOL_F_AL_CTL];
  end

  // next state: mirrors, masks, read data, masked outputs
  always_comb
  begin
    next_r = r;
    next_r.sm_mirror = i_sm_status;
    next_r.sm_irq = fold_irq(i_sm_irq_bits);
    if (i_net_wr && word_hit(i_net_addr, SERCOL_NET_MASK_OFF))
      next_r.net_mask = 16'(lane_merge({16'h0000, r.net_mask}, i_net_wdata, i_net_be));
    if (i_host_wr && word_hit(i_host_addr, SERCOL_HOST_MASK_OFF))
      next_r.host_mask = lane_merge(r.host_mask, i_host_wdata, i_host_be);
    // request words ignore writes from both sides
    // byte n of a word sits in lane n
    if (i_net_rd)
    begin
      next_r.net_rdata = 32'h00000000;
      if (word_hit(i_net_addr, SERCOL_NET_MASK_OFF))
        next_r.net_rdata = {16'h0000, r.net_mask};
      else if (word_hit(i_net_addr, SERCOL_HOST_MASK_OFF))
        next_r.net_rdata = r.host_mask;
      else if (word_hit(i_net_addr, SERCOL_NET_REQ_OFF))
        next_r.net_rdata = {16'h0000, net_req};
      // 32-bit word from the master side too
      else if (word_hit(i_net_addr, SERCOL_HOST_REQ_OFF))
        next_r.net_rdata = host_req;
    end
    if (i_host_rd)
    begin
      next_r.host_rdata = 32'h00000000;
      if (word_hit(i_host_addr, SERCOL_NET_MASK_OFF))
        next_r.host_rdata = {16'h0000, r.net_mask};
      else if (word_hit(i_host_addr, SERCOL_HOST_MASK_OFF))
        next_r.host_rdata = r.host_mask;
      else if (word_hit(i_host_addr, SERCOL_NET_REQ_OFF))
        next_r.host_rdata = {16'h0000, net_req};
      else if (word_hit(i_host_addr, SERCOL_HOST_REQ_OFF))
        next_r.host_rdata = host_req;
    end
    // interrupt follows masked requests as a level
    next_r.host_irq = |(host_req & r.host_mask);
    next_r.net_field = net_req & r.net_mask;
  end

  // state register; masks come up at their documented values
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      r <= '0;
      r.net_mask <= SERCOL_NET_MASK_RST;
      r.host_mask <= SERCOL_HOST_MASK_RST;
    end
    else
      r <= next_r;
  end

  // outputs straight from flops, one cycle behind the requests
  assign o_net_rdata = r.net_rdata;
  assign o_host_rdata = r.host_rdata;
  assign o_host_interrupt_request = r.host_irq;
  assign o_net_event_field = r.net_field;

  // checks, all in the core clock domain
  default clocking sercol_cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  // mirror follows channel status one cycle late
  a_sm_status_mirror: assert property (
    ##1 net_req[11:4] == $past(i_sm_status))
    else $error("channel status mirror wrong");

  // status change sets, lone read clears
  a_al_status_set: assert property (
    i_al_status_change |=> net_req[3] [*1] ##0 1'b1)
    else $error("status event not set");

  a_al_status_clr: assert property (
    i_al_status_net_read && !i_al_status_change |=> !net_req[3])
    else $error("status event not cleared");

  a_dl_status_hold: assert property (
    net_req[2] && !i_dl_status_net_read |=> net_req[2])
    else $error("link event dropped early");

  // latch change reaches both words together
  a_latch_both: assert property (
    i_latch_change |=> net_req[0] && host_req[1])
    else $error("latch event missing");

  a_net_reserved: assert property (
    i_net_rd && word_hit(i_net_addr, SERCOL_NET_REQ_OFF)
    |=> o_net_rdata[31:12] == 20'h00000 && !o_net_rdata[1])
    else $error("network word reserved bits set");

  // host word read returns requests, reserved low
  a_host_read: assert property (
    i_host_rd && word_hit(i_host_addr, SERCOL_HOST_REQ_OFF)
    |=> o_host_rdata == $past(host_req) && o_host_rdata[31:16] == 16'h0000
        && !o_host_rdata[7])
    else $error("host word read wrong");

  // watchdog flag stays until status read
  a_wdog_sticky: assert property (
    i_wdog_expired ##1 !i_wdog_status_read [*2] |=> host_req[6])
    else $error("watchdog flag lost");

  a_eeprom_ack: assert property (
    host_req[5] && i_eeprom_ack && !i_eeprom_cmd |=> !host_req[5])
    else $error("eeprom ack ignored");

  a_first_sync_output_gate: assert property (
    !host_req[2] && !i_sync_latch_cfg[3] |=> !host_req[2])
    else $error("first sync set while disabled");

  a_second_sync_output_gate: assert property (
    !host_req[3] && !i_sync_latch_cfg[7] |=> !host_req[3])
    else $error("second sync set while disabled");

  a_ctl_emulation: assert property (
    !host_req[0] && i_host_emulation |=> !host_req[0])
    else $error("control event under emulation");

  // network side cannot change the host mask
  a_host_mask_ro: assert property (
    !(i_host_wr && word_hit(i_host_addr, SERCOL_HOST_MASK_OFF))
    |=> $stable(r.host_mask))
    else $error("host mask changed without host write");

  a_irq_level: assert property (
    ##1 o_host_interrupt_request == |($past(host_req) & $past(r.host_mask)))
    else $error("interrupt level wrong");

  // main scenarios
  c_irq_rise: cover property ($rose(o_host_interrupt_request));
  c_eeprom_cycle: cover property (i_eeprom_cmd ##[1:20] i_eeprom_ack);
  c_net_field: cover property (|o_net_event_field);
  c_set_and_clear: cover property (i_wdog_expired && i_wdog_status_read);
endmodule : sercol_collector

// File: design/sercol_pkg.sv
/*
  package for the slave event request collector: offsets, bit positions,
  reset values. assumes byte addresses on both register ports.
*/
package sercol_pkg;
  // register offsets (byte addresses)
  localparam logic [11:0] SERCOL_NET_MASK_OFF = 12'h200;
  localparam logic [11:0] SERCOL_HOST_MASK_OFF = 12'h204;
  localparam logic [11:0] SERCOL_NET_REQ_OFF = 12'h210;
  localparam logic [11:0] SERCOL_HOST_REQ_OFF = 12'h220;
  // reset values
  localparam logic [15:0] SERCOL_NET_MASK_RST = 16'h0000;
  localparam logic [31:0] SERCOL_HOST_MASK_RST = 32'h00ffff0f;
  // network side request word layout
  localparam int SERCOL_NET_SM_LO = 4;
  localparam int SERCOL_NET_AL_STAT = 3;
  localparam int SERCOL_NET_DL_STAT = 2;
  localparam int SERCOL_NET_LATCH = 0;
  // host side request word layout
  localparam int SERCOL_HOST_SM_LO = 8;
  localparam int SERCOL_HOST_WDOG = 6;
  localparam int SERCOL_HOST_EEPROM = 5;
  localparam int SERCOL_HOST_SM_ACT = 4;
  localparam int SERCOL_HOST_SECOND_SYNC_OUTPUT = 3;
  localparam int SERCOL_HOST_FIRST_SYNC_OUTPUT = 2;
  localparam int SERCOL_HOST_LATCH = 1;
  localparam int SERCOL_HOST_AL_CTL = 0;
  // sync/latch host configuration enables
  localparam int SERCOL_CFG_SECOND_SYNC_OUTPUT_EN = 7;
  localparam int SERCOL_CFG_FIRST_SYNC_OUTPUT_EN = 3;
  // sticky flag bank indices
  localparam int SERCOL_F_NET_AL = 0;
  localparam int SERCOL_F_NET_DL = 1;
  localparam int SERCOL_F_NET_LATCH = 2;
  localparam int SERCOL_F_AL_CTL = 3;
  localparam int SERCOL_F_H_LATCH = 4;
  localparam int SERCOL_F_FIRST_SYNC_OUTPUT = 5;
  localparam int SERCOL_F_SECOND_SYNC_OUTPUT = 6;
  localparam int SERCOL_F_SM_ACT = 7;
  localparam int SERCOL_F_EEPROM = 8;
  localparam int SERCOL_F_WDOG = 9;
  localparam int SERCOL_NUM_FLAGS = 10;
endpackage : sercol_pkg

// File: design/sercol_flag_bank.sv
/*
  bank of sticky event flags, set wins over clear.
  assumes set and clear are single-cycle pulses in the core clock domain.
*/
`timescale 1ns/1ns
module sercol_flag_bank
  import sercol_pkg::*;
#(
  parameter int W = 10
)
(
  input wire logic i_sys_clk, // core clock
  input wire logic i_rst, // async reset, active high
  input wire logic [W-1:0] i_set, // set pulses
  input wire logic [W-1:0] i_clr, // clear pulses
  output logic [W-1:0] o_flags // sticky flags
);
  typedef struct packed {
    logic [W-1:0] flags;
  } sercol_bank_type;

  sercol_bank_type r;
  sercol_bank_type next_r;

  // set beats clear so an event in the clear cycle is kept
  always_comb
  begin
    next_r = r;
    next_r.flags = i_set | (r.flags & ~i_clr);
  end

  // state register
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      r <= '0;
    else
      r <= next_r;
  end

  assign o_flags = r.flags;

  a_set_wins: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    |i_set |=> ((o_flags & $past(i_set)) == $past(i_set)))
    else $error("set pulse lost in flag bank");
endmodule : sercol_flag_bank

// File: tb/sercol_src_model.sv
/*
  source side model: the sync manager, status, latch, watchdog, eeprom
  and sync blocks that feed the collector. assumes requests from the
  bench arrive on i_sys_clk and are replayed one cycle later.
*/
`timescale 1ns/1ns
module sercol_src_model
  import sercol_pkg::*;
(
  input wire logic i_sys_clk, // core clock
  input wire logic i_rst, // async reset, active high
  input wire logic [18:0] i_cmd, // pulse requests
  input wire logic [7:0] i_sm_req, // wanted channel status
  input wire logic [15:0] i_irq_req, // wanted channel irq bits
  output logic [18:0] o_pulse, // one-cycle event pulses
  output logic [7:0] o_sm_status, // channel status levels
  output logic [15:0] o_sm_irq_bits // channel irq levels
);
  // launch just after the edge so the collector samples a clean pulse
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_pulse <= '0;
      o_sm_status <= '0;
      o_sm_irq_bits <= '0;
    end
    else
    begin
      o_pulse <= i_cmd;
      o_sm_status <= i_sm_req;
      o_sm_irq_bits <= i_irq_req;
    end
  end
endmodule : sercol_src_model

// File: tb/test_slave_event_request_collector.sv
/*
  self-checking bench for the event request collector: reads and writes
  both register ports, drives event sources through the source model.
  assumes the one-cycle read latency and two-cycle event latency.
*/
`timescale 1ns/1ns
module test_slave_event_request_collector;
  import sercol_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [11:0] net_addr = '0, host_addr = '0;
  logic net_rd = 0, net_wr = 0, host_rd = 0, host_wr = 0;
  logic [3:0] net_be = '0, host_be = '0;
  logic [31:0] net_wd = '0, host_wd = '0;
  logic [31:0] net_rdata, host_rdata;
  logic [18:0] cmd = '0, pulse;
  logic [7:0] sm_req = '0, sm_st, cfg = '0;
  logic [15:0] irq_req = '0, irq_bits, field;
  logic emul = 1'b0, irq, pend_h = 0, pend_n = 0;
  logic [31:0] host_q[$], net_q[$];
  int num_errors = 0, check_count = 0;
  integer seed = 99525;
  logic [7:0] ored;
  int st[8] = '{0, 2, 7, 9, 11, 13, 14, 17};
  int cl[8] = '{1, 3, 8, 10, 12, 15, 16, 18};
  int bt[8] = '{3, 2, 6, 5, 4, 2, 3, 0};
  bit sd[8] = '{0, 0, 1, 1, 1, 1, 1, 1};

  always #2 i_sys_clk = ~i_sys_clk;

  sercol_src_model src (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cmd(cmd),
    .i_sm_req(sm_req), .i_irq_req(irq_req), .o_pulse(pulse),
    .o_sm_status(sm_st), .o_sm_irq_bits(irq_bits));

  sercol_collector #(.NUM_SM(8)) uut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_net_addr(net_addr), .i_net_rd(net_rd), .i_net_wr(net_wr),
    .i_net_be(net_be), .i_net_wdata(net_wd), .o_net_rdata(net_rdata),
    .i_host_addr(host_addr), .i_host_rd(host_rd), .i_host_wr(host_wr),
    .i_host_be(host_be), .i_host_wdata(host_wd), .o_host_rdata(host_rdata),
    .i_sm_status(sm_st), .i_sm_irq_bits(irq_bits),
    .i_al_status_change(pulse[0]), .i_al_status_net_read(pulse[1]),
    .i_dl_status_change(pulse[2]), .i_dl_status_net_read(pulse[3]),
    .i_latch_change(pulse[4]), .i_latch_net_read(pulse[5]),
    .i_latch_host_read(pulse[6]), .i_wdog_expired(pulse[7]),
    .i_wdog_status_read(pulse[8]), .i_eeprom_cmd(pulse[9]),
    .i_eeprom_ack(pulse[10]), .i_sm_act_change(pulse[11]),
    .i_sm_act_host_read(pulse[12]), .i_first_sync_output(pulse[13]), .i_second_sync_output(pulse[14]),
    .i_sync_latch_cfg(cfg), .i_first_sync_output_status_read(pulse[15]),
    .i_second_sync_output_status_read(pulse[16]), .i_al_control_write(pulse[17]),
    .i_al_control_host_read(pulse[18]), .i_host_emulation(emul),
    .o_host_interrupt_request(irq), .o_net_event_field(field));

  task automatic end_sim;
    if (num_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t read %h expected %h", $time, g, e);
    end
  endtask : chk_rd

  task automatic chk_evt(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t event output %h expected %h", $time, g, e);
    end
  endtask : chk_evt

  // one read on either port, expected word noted for the monitor
  task automatic rd(input bit h, input logic [11:0] a, input logic [31:0] e);
    @(posedge i_sys_clk);
    host_addr <= a;
    net_addr <= a;
    host_rd <= h;
    net_rd <= !h;
    if (h)
      host_q.push_back(e);
    else
      net_q.push_back(e);
    @(posedge i_sys_clk);
    host_rd <= 1'b0;
    net_rd <= 1'b0;
  endtask : rd

  task automatic wr(input bit h, input logic [11:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    @(posedge i_sys_clk);
    host_addr <= a;
    net_addr <= a;
    host_be <= be;
    net_be <= be;
    host_wd <= d;
    net_wd <= d;
    host_wr <= h;
    net_wr <= !h;
    @(posedge i_sys_clk);
    host_wr <= 1'b0;
    net_wr <= 1'b0;
  endtask : wr

  // returns once the collector has sampled the pulse
  task automatic fire(input logic [18:0] v);
    @(posedge i_sys_clk);
    cmd <= v;
    @(posedge i_sys_clk);
    cmd <= '0;
    @(posedge i_sys_clk);
  endtask : fire

  // irq and field settle one cycle after the sampling edge
  task automatic evt_chk(input logic [15:0] g_sel, input logic [15:0] e);
    repeat (3) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    chk_evt(g_sel ? field : {15'h0, irq}, e);
  endtask : evt_chk

  // rdata is taken one cycle after the read edge
  always @(posedge i_sys_clk)
  begin
    pend_h <= host_rd;
    pend_n <= net_rd;
  end

  always @(negedge i_sys_clk)
  begin
    if (pend_h)
      chk_rd(host_rdata, host_q.pop_front());
    if (pend_n)
      chk_rd(net_rdata, net_q.pop_front());
  end

  // hang guard, far above the sequence length
  initial
  begin
    repeat (20000) @(posedge i_sys_clk);
    num_errors++;
    end_sim();
  end

  initial
  begin
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rd(1, 12'h204, 32'h00ffff0f);
    rd(1, 12'h200, 32'h0);
    rd(0, 12'h210, 32'h0);
    rd(1, 12'h220, 32'h0);
    rd(0, 12'h300, 32'h0);
    // random channel levels seen through both words
    for (int k = 0; k < 4; k++)
    begin
      @(posedge i_sys_clk);
      sm_req <= 8'($random(seed));
      irq_req <= 16'($random(seed));
      repeat (3) @(posedge i_sys_clk);
      for (int i = 0; i < 8; i++)
        ored[i] = irq_req[2*i] | irq_req[2*i+1];
      rd(0, 12'h210, {20'h0, sm_req, 4'h0});
      rd(1, 12'h220, {16'h0, ored, 8'h0});
    end
    @(posedge i_sys_clk);
    sm_req <= '0;
    irq_req <= '0;
    cfg <= 8'h88;
    repeat (3) @(posedge i_sys_clk);
    // each sticky event but latch: set, read, clear, read
    for (int i = 0; i < 8; i++)
    begin
      fire(19'h1 << st[i]);
      rd(sd[i], sd[i] ? 12'h220 : 12'h210, 32'h1 << bt[i]);
      fire(19'h1 << cl[i]);
      rd(sd[i], sd[i] ? 12'h220 : 12'h210, 32'h0);
    end
    // latch change lands in both words, each cleared by its own reader
    fire(19'h10);
    rd(0, 12'h210, 32'h1);
    rd(1, 12'h220, 32'h2);
    fire(19'h20);
    rd(0, 12'h210, 32'h0);
    rd(1, 12'h220, 32'h2);
    fire(19'h40);
    rd(1, 12'h220, 32'h0);
    // set and clear together: set wins
    fire(19'h180);
    rd(1, 12'h220, 32'h40);
    fire(19'h100);
    // sync disabled and emulation on: no events
    @(posedge i_sys_clk);
    cfg <= 8'h77;
    emul <= 1'b1;
    fire(19'h26000);
    rd(1, 12'h220, 32'h0);
    @(posedge i_sys_clk);
    cfg <= 8'h88;
    emul <= 1'b0;
    // request words cannot be written
    wr(1, 12'h220, 4'hf, 32'hffffffff);
    wr(0, 12'h210, 4'hf, 32'hffffffff);
    rd(1, 12'h220, 32'h0);
    rd(0, 12'h210, 32'h0);
    // host interrupt follows masked pending bits
    wr(1, 12'h204, 4'hf, 32'h40);
    fire(19'h80);
    evt_chk(16'h0, 16'h1);
    wr(1, 12'h204, 4'hf, 32'h0);
    evt_chk(16'h0, 16'h0);
    wr(1, 12'h204, 4'hf, 32'h40);
    evt_chk(16'h0, 16'h1);
    fire(19'h100);
    evt_chk(16'h0, 16'h0);
    // network mask gates the frame field, byte lanes by enable
    wr(0, 12'h200, 4'h3, 32'h4);
    fire(19'h4);
    evt_chk(16'h1, 16'h4);
    wr(0, 12'h200, 4'h2, 32'h0000ff00);
    wr(1, 12'h200, 4'hf, 32'h0);
    rd(1, 12'h200, 32'h0000ff04);
    evt_chk(16'h1, 16'h4);
    // mid-run reset brings both masks back to their reset values
    @(posedge i_sys_clk);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rd(0, 12'h200, 32'h0);
    rd(0, 12'h204, 32'h00ffff0f);
    rd(1, 12'h210, 32'h0);
    evt_chk(16'h0, 16'h0);
    repeat (2) @(posedge i_sys_clk);
    end_sim();
  end
endmodule : test_slave_event_request_collector
